/* File: hw/sfir_top.sv */
// Folded FIR filter: four chained multiply-add elements and a final accumulator.
//
// Function
// [RL1] Output is sum of coefficient times delayed sample.
// [RL2] One result every four cycles, sixteen coefficients.
// [RL3] Elements cascade sums, each one cycle later.
// [RL4] Two pipeline registers on each coefficient operand.
// [RL5] Final accumulator sums partials from last element.
// [RL6] Adder select switches to load for one cycle.
// [RL7] Capture register loads when accumulator loads.
// [RL8] Four-sample buffers shifted once every four cycles.
// [RL9] Extra register after each sample buffer read.
// [RL10] Coefficients split in order, four per memory.
// [RL11] Coefficient set padded with zeros to fit.
// [RL12] Cascade and accumulator carry 48-bit precision.
// [RL13] Eighteen-bit coefficients in small per-element memories.
// [RL14] Counter zero to three; delayed copies address elements.
// [RL15] Compare gives one-in-four enable, delayed per element.
// [RL16] Output takes accumulator bits 34 down to 17; reset clears pipeline.
`timescale 1ns/1ps
module sfir_top #(
    parameter int NUM_MULT = sfir_pkg::SFIR_NUM_MULT,
    parameter int OUT_SHIFT = sfir_pkg::SFIR_OUT_SHIFT
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire sfir_pkg::sfir_samp_t in_data,
    input wire logic in_valid,
    output logic in_ready,
    output sfir_pkg::sfir_samp_t out_data,
    output logic out_valid,
    input wire logic out_ready
);
    import sfir_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    localparam int CHAIN = NUM_MULT - 1 + SFIR_ELEM_LAT;

    typedef struct packed {
        logic [SFIR_AW-1:0] cnt;
        sfir_ctrl_s [CHAIN:1] ctrl;
        sfir_samp_t hold;
        logic hold_v;
        logic in_rdy;
        sfir_sel_e sel;
        sfir_acc_t acc;
        logic [SFIR_FIFO_DEPTH-1:0][SFIR_DW-1:0] fifo;
        logic [1:0] fcnt;
        logic ov;
    } sfir_top_state_s;

    sfir_top_state_s s_q;
    sfir_top_state_s s_d;

    sfir_ctrl_s ctrl0;
    logic ce0;
    logic run;
    logic push;
    logic pop;
    sfir_samp_t result;
    sfir_ctrl_s elem_ctrl [NUM_MULT];
    sfir_samp_t samp_chain [NUM_MULT+1];
    sfir_acc_t pc_chain [NUM_MULT+1];

    // ****************************************************************
    // Sequencing
    // ****************************************************************
    assign ce0 = (s_q.cnt == SFIR_CNT_MAX); // [RL15] [RL2]
    assign ctrl0 = '{ce: ce0, addr: s_q.cnt};
    // The whole pipeline freezes when no sample is waiting at the write
    // slot or the output buffer is full, so no word is ever dropped.
    assign run = (s_q.fcnt != 2'(SFIR_FIFO_DEPTH)) && (!ce0 || s_q.hold_v);
    assign push = run && (s_q.sel == SFIR_SEL_LOAD); // [RL7]
    assign pop = s_q.ov && out_ready;
    assign result = s_q.acc[OUT_SHIFT +: SFIR_DW]; // [RL16]

    // ****************************************************************
    // Element chain
    // ****************************************************************
    assign samp_chain[0] = s_q.hold;
    assign pc_chain[0] = '0;

    for (genvar k = 0; k < NUM_MULT; k++) begin : g_elem
        if (k == 0) begin : g_first
            assign elem_ctrl[k] = ctrl0; // [RL14]
        end else begin : g_next
            assign elem_ctrl[k] = s_q.ctrl[k]; // [RL14] [RL15]
        end
        sfir_madd #(
            .GROUP(k),
            .TAPS(SFIR_TAPS)
        ) u_madd (
            .clock(clock),
            .rst_n(rst_n),
            .en(run),
            .ctrl(elem_ctrl[k]),
            .samp_in(samp_chain[k]),
            .pcin(pc_chain[k]),
            .samp_out(samp_chain[k+1]),
            .pcout(pc_chain[k+1]) // [RL3]
        );
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        if (in_valid && s_q.in_rdy) begin
            s_d.hold = in_data;
            s_d.hold_v = 1'b1;
        end
        if (run && ce0) begin
            s_d.hold_v = 1'b0; // [RL8]
        end
        s_d.in_rdy = !s_d.hold_v;
        if (run) begin
            if (ce0) begin
                s_d.cnt = SFIR_CNT_FIRST; // [RL14]
            end else begin
                s_d.cnt = s_q.cnt + 2'h1;
            end
            s_d.ctrl[1] = ctrl0;
            for (int k = 2; k <= CHAIN; k++) begin
                s_d.ctrl[k] = s_q.ctrl[k-1]; // [RL15]
            end
            // The delayed enable marks a real phase change; the cleared
            // address after reset would otherwise fake a run of loads.
            if (s_q.ctrl[CHAIN].ce) begin
                s_d.sel = SFIR_SEL_LOAD; // [RL6]
            end else begin
                s_d.sel = SFIR_SEL_ACC; // [RL6]
            end
            if (s_q.sel == SFIR_SEL_LOAD) begin
                s_d.acc = pc_chain[NUM_MULT]; // [RL5]
            end else begin
                s_d.acc = s_q.acc + pc_chain[NUM_MULT]; // [RL5] [RL1] [RL12]
            end
        end
        case ({push, pop})
            2'b10: begin
                s_d.fifo[s_q.fcnt[0]] = result; // [RL7]
                s_d.fcnt = s_q.fcnt + 2'h1;
            end
            2'b01: begin
                s_d.fifo[0] = s_q.fifo[1];
                s_d.fcnt = s_q.fcnt - 2'h1;
            end
            2'b11: begin
                if (s_q.fcnt == 2'h1) begin
                    s_d.fifo[0] = result;
                end else begin
                    s_d.fifo[0] = s_q.fifo[1];
                    s_d.fifo[1] = result;
                end
            end
            default: begin
                s_d.fcnt = s_q.fcnt;
            end
        endcase
        s_d.ov = (s_d.fcnt != 2'h0);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_q <= '{sel: SFIR_SEL_ACC, in_rdy: 1'b1, default: '0}; // [RL16]
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign in_ready = s_q.in_rdy;
    assign out_data = s_q.fifo[0];
    assign out_valid = s_q.ov;

endmodule

/* File: hw/sfir_pkg.sv */
// Shared constants, types and coefficient set of the folded FIR filter.
package sfir_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int SFIR_NUM_COEF = 16;
    localparam int SFIR_NUM_MULT = 4;
    localparam int SFIR_TAPS = (SFIR_NUM_COEF + SFIR_NUM_MULT - 1) / SFIR_NUM_MULT;
    localparam int SFIR_AW = 2;
    localparam int SFIR_DW = 18;
    localparam int SFIR_CW = 18;
    localparam int SFIR_PW = 48;
    localparam int SFIR_MW = SFIR_DW + SFIR_CW;
    localparam int SFIR_OUT_SHIFT = 17;
    localparam int SFIR_FIFO_DEPTH = 2;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam logic [SFIR_AW-1:0] SFIR_CNT_MAX = 2'h3;
    localparam logic [SFIR_AW-1:0] SFIR_CNT_FIRST = 2'h0;
    localparam int SFIR_ELEM_LAT = 5;
    localparam int SFIR_CHAIN = SFIR_NUM_MULT - 1 + SFIR_ELEM_LAT;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef logic signed [SFIR_DW-1:0] sfir_samp_t;
    typedef logic signed [SFIR_CW-1:0] sfir_coef_t;
    typedef logic signed [SFIR_PW-1:0] sfir_acc_t;

    typedef enum logic [6:0] {
        SFIR_SEL_LOAD = 7'h10,
        SFIR_SEL_ACC = 7'h12
    } sfir_sel_e;

    typedef struct packed {
        logic ce;
        logic [SFIR_AW-1:0] addr;
    } sfir_ctrl_s;

    // ****************************************************************
    // Coefficients
    // ****************************************************************
    localparam sfir_coef_t SFIR_COEF [SFIR_NUM_COEF] = '{
        18'sh00100, 18'sh00200, 18'sh00400, 18'sh00800,
        18'sh01000, 18'sh02000, 18'sh04000, 18'sh08000,
        18'sh08000, 18'sh04000, 18'sh02000, 18'sh01000,
        18'sh00800, 18'sh00400, 18'sh00200, 18'sh00100
    };

    // Coefficient of one element and tap; indices past the set read zero.
    function automatic sfir_coef_t sfir_coef_at(input int group, input int tap);
        int idx;
        idx = group * SFIR_TAPS + tap;
        if (idx < SFIR_NUM_COEF) begin
            return SFIR_COEF[idx];
        end
        return '0;
    endfunction

endpackage

/* File: hw/sfir_madd.sv */
// One multiply-add element: sample buffer, coefficient memory and cascade adder.
`timescale 1ns/1ps
module sfir_madd #(
    parameter int GROUP = 0,
    parameter int TAPS = sfir_pkg::SFIR_TAPS
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic en,
    input wire sfir_pkg::sfir_ctrl_s ctrl,
    input wire sfir_pkg::sfir_samp_t samp_in,
    input wire sfir_pkg::sfir_acc_t pcin,
    output sfir_pkg::sfir_samp_t samp_out,
    output sfir_pkg::sfir_acc_t pcout
);
    import sfir_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [TAPS-1:0][SFIR_DW-1:0] sbuf;
        sfir_samp_t carry;
        sfir_samp_t rd;
        sfir_samp_t a1;
        sfir_samp_t a2;
        sfir_coef_t c0;
        sfir_coef_t c1;
        sfir_coef_t c2;
        logic signed [SFIR_MW-1:0] m;
        sfir_acc_t p;
    } sfir_madd_state_s;

    sfir_madd_state_s s_q;
    sfir_madd_state_s s_d;
    sfir_coef_t cmem [TAPS];

    // ****************************************************************
    // Coefficient memory
    // ****************************************************************
    for (genvar i = 0; i < TAPS; i++) begin : g_cmem
        assign cmem[i] = sfir_coef_at(GROUP, i); // [RL10] [RL11] [RL13]
    end

    // ****************************************************************
    // Datapath
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        if (en) begin
            if (ctrl.ce) begin
                s_d.sbuf[0] = samp_in; // [RL8]
                for (int j = 1; j < TAPS; j++) begin
                    s_d.sbuf[j] = s_q.sbuf[j-1];
                end
                s_d.carry = s_q.sbuf[TAPS-1];
            end
            s_d.rd = s_q.sbuf[ctrl.addr]; // [RL9] [RL14]
            s_d.a1 = s_q.rd;
            s_d.a2 = s_q.a1;
            s_d.c0 = cmem[ctrl.addr]; // [RL13]
            s_d.c1 = s_q.c0; // [RL4]
            s_d.c2 = s_q.c1; // [RL4]
            s_d.m = s_q.a2 * s_q.c2;
            s_d.p = SFIR_PW'(s_q.m) + pcin; // [RL3] [RL12]
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_q <= '0; // [RL16]
        end else begin
            s_q <= s_d;
        end
    end

    assign samp_out = s_q.carry;
    assign pcout = s_q.p;

endmodule

/* File: bench/sfir_monitor.sv */
// Port checker for the folded FIR filter.
`timescale 1ns/1ps
module sfir_monitor (
    input wire logic clock,
    input wire logic rst_n,
    input wire sfir_pkg::sfir_samp_t in_data,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire sfir_pkg::sfir_samp_t out_data,
    input wire logic out_valid,
    input wire logic out_ready
);
    import sfir_pkg::*;
    logic [7:0] pend_q;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge clock) begin
        if (!rst_n) pend_q <= '0;
        else pend_q <= pend_q + 8'(in_valid && in_ready) - 8'(out_valid && out_ready);
    end
    rst_out_a: assert property (disable iff (1'b0) !rst_n |=> !out_valid && out_data == '0)
        else $error("output not cleared by reset");
    rst_ready_a: assert property (disable iff (1'b0) !rst_n |=> in_ready)
        else $error("input not ready after reset");
    take_drop_a: assert property (in_valid && in_ready |=> !in_ready)
        else $error("second sample taken without a gap");
    ready_fall_a: assert property ($fell(in_ready) |-> $past(in_valid))
        else $error("input ready fell without a take");
    out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("result lost while stalled");
    out_drop_a: assert property ($fell(out_valid) |-> $past(out_ready))
        else $error("result withdrawn without a pop");
    pair_a: assert property (out_valid |-> pend_q != 8'h0)
        else $error("result without a sample");
    no_starve_a: assert property (not ((!in_ready && out_ready) [*8]))
        else $error("held sample not consumed");
endmodule
bind sfir_top sfir_monitor mon (.clock(clock), .rst_n(rst_n), .in_data(in_data),
    .in_valid(in_valid), .in_ready(in_ready), .out_data(out_data), .out_valid(out_valid),
    .out_ready(out_ready));

/* File: bench/sfir_sink.sv */
// Downstream result sink that can stall.
`timescale 1ns/1ps
module sfir_sink (
    input wire logic clock,
    input wire logic [1:0] mode,
    input wire sfir_pkg::sfir_samp_t out_data,
    input wire logic out_valid,
    output logic out_ready
);
    import sfir_pkg::*;
    sfir_samp_t got[$];
    logic [1:0] cnt_q = '0;
    initial out_ready = 1'b0;
    always @(posedge clock) begin
        if (out_valid && out_ready) got.push_back(out_data);
        cnt_q <= cnt_q + 2'h1;
        out_ready <= (mode == 2'h0) || (mode == 2'h1 && cnt_q[1]);
    end
endmodule

/* File: bench/tb_sfir_top.sv */
// Self-checking bench of the folded FIR filter.
`timescale 1ns/1ps
`define CHK(nm, s, e) begin n_tests++; if ((s) !== (e)) begin miscompares++; $display("Error %s expected %0h seen %0h", nm, e, s); end end
module tb_sfir_top;
    import sfir_pkg::*;
    localparam int NS = 20;
    logic clock, rst_n, in_valid, in_ready, out_valid, out_ready;
    sfir_samp_t in_data, out_data;
    logic [1:0] pmode;
    int miscompares, n_tests, cyc;
    sfir_samp_t xs[NS];
    sfir_top uut (.clock(clock), .rst_n(rst_n), .in_data(in_data), .in_valid(in_valid),
        .in_ready(in_ready), .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready));
    sfir_sink peer (.clock(clock), .mode(pmode), .out_data(out_data), .out_valid(out_valid),
        .out_ready(out_ready));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic final_report();
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (16) @(posedge clock);
        #1;
        rst_n = 1'b1;
        peer.got.delete();
        `CHK("in_ready", in_ready, 1'b1)
        `CHK("out_valid", out_valid, 1'b0)
    endtask
    task automatic feed(input logic st);
        int i, c, lc;
        i = 0;
        lc = 0;
        for (c = 0; c < 600 && i < NS + 8; c++) begin
            pmode = (st && c < 60) ? 2'h2 : {1'b0, st};
            in_data = (i < NS) ? xs[i] : '0;
            in_valid = 1'b1;
            @(negedge clock);
            if (st && c == 59) `CHK("refused", in_ready, 1'b0)
            if (in_ready === 1'b1) begin
                if (!st && i > 4 && i < NS) `CHK("gap", c - lc, 4)
                lc = c;
                i++;
            end
            @(posedge clock);
            #1;
        end
        in_valid = 1'b0;
        pmode = 2'h0;
    endtask
    task automatic judge();
        sfir_acc_t acc;
        sfir_samp_t ex;
        int k, t, n, j;
        t = 0;
        while (peer.got.size() < NS + 3 && t < 500) begin
            @(posedge clock);
            t++;
        end
        `CHK("coef_fit", SFIR_NUM_COEF % SFIR_NUM_MULT, 0)
        k = 0;
        while (k < 4 && peer.got[k] === '0) k++;
        for (n = 0; n < NS; n++) begin
            acc = '0;
            for (j = 0; j < SFIR_NUM_COEF && j <= n; j++) acc += SFIR_COEF[j] * xs[n - j];
            ex = acc[SFIR_OUT_SHIFT +: SFIR_DW];
            `CHK("result", peer.got[k + n], ex)
        end
    endtask
    task automatic scen_stream();
        do_reset();
        feed(1'b0);
        judge();
    endtask
    task automatic scen_stall();
        do_reset();
        feed(1'b1);
        judge();
    endtask
    initial begin
        rst_n = 1'b0;
        in_valid = 1'b0;
        in_data = '0;
        pmode = 2'h0;
        miscompares = 0;
        n_tests = 0;
        cyc = 0;
        for (int n = 0; n < NS; n++) xs[n] = 18'h1ffff - 18'(n * 18'h2711);
        scen_stream();
        scen_stall();
        final_report();
    end
endmodule
